//--- v110_channel_descriptor_events_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module v110_channel_descriptor_events_tb_top;
  import vce_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, host_irq, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ser_rxd, ser_txd, ser_tick, cmd_enter_hunt, cmd_restart_tx;
  logic [7:0] b0, b1;
  logic txq[$];
  logic rxq[$];
  logic [7:0] bq[$];
  int miscompares = 0;
  int checks = 0;
  integer seed = 32'h7d52;
  vce_link lnk_if();
  vce_dev #(.BIT_DIV(16)) vce_dev_inst (.clk(clk), .nrst(nrst), .lnk(lnk_if), .ser_rxd(ser_rxd),
    .ser_txd(ser_txd), .ser_tick(ser_tick), .cmd_enter_hunt(cmd_enter_hunt), .cmd_restart_tx(cmd_restart_tx));
  vce_host vce_host_inst (.clk(clk), .nrst(nrst), .lnk(lnk_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .host_irq(host_irq));
  vce_link_chk vce_link_chk_inst (.clk(clk), .nrst(nrst), .mem_req(lnk_if.mem_req), .mem_we(lnk_if.mem_we),
    .mem_ext(lnk_if.mem_ext), .mem_addr(lnk_if.mem_addr), .mem_ack(lnk_if.mem_ack),
    .reg_req(lnk_if.reg_req), .reg_we(lnk_if.reg_we), .reg_addr(lnk_if.reg_addr),
    .reg_wdata(lnk_if.reg_wdata), .reg_ack(lnk_if.reg_ack), .reg_rdata(lnk_if.reg_rdata), .irq(lnk_if.irq));
  always #25 clk = ~clk;
  // ==========================================
  // Serial line: one bit per tick each way
  always @(posedge clk) begin
    if (ser_tick === 1'b1) begin
      txq.push_back(ser_txd);
      ser_rxd <= (rxq.size() > 0) ? rxq.pop_front() : 1'b1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] ia(input int w);
    return 16'h1000 + 16'(w * 4);
  endfunction
  // Waits for the controller to hand a descriptor back
  task automatic poll(input logic [15:0] a);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[15] !== 1'b0 && n < 600);
  endtask
  task automatic send_frame(input int nbytes, input int bad);
    logic [7:0] b;
    bq.delete();
    repeat (8) rxq.push_back(1'b0);
    for (int i = 0; i < nbytes; i++) begin
      b = 8'($random(seed)) | 8'h80;
      if (i == bad) b[7] = 1'b0;
      bq.push_back(b);
      for (int k = 7; k >= 0; k--) rxq.push_back(b[k]);
    end
  endtask
  task automatic wait_rx();
    for (int n = 0; n < 3000 && rxq.size() > 0; n++) @(posedge clk);
    repeat (64) @(posedge clk);
  endtask
  task automatic rx_check();
    apb(1'b0, ia(1), 32'h0);
    chk(rd, 32'(bq.size()));
    for (int i = 0; i < (bq.size() + 1) / 2; i++) begin
      apb(1'b0, ia(8'h50 + i), 32'h0);
      chk(32'(rd[15:8]), 32'(bq[2*i]));
      if (2*i + 1 < bq.size()) chk(32'(rd[7:0]), 32'(bq[2*i+1]));
    end
  endtask
  // Bits on the line after idle ones must be the two bytes, MSB first, then ones again
  task automatic tx_check(input logic [15:0] exp);
    int i;
    logic [15:0] got;
    logic ones;
    i = 0;
    while (i < txq.size() && txq[i] === 1'b1) i++;
    for (int k = 0; k < 16; k++) got[15-k] = (i + k < txq.size()) ? txq[i+k] : 1'bx;
    chk(32'(got), 32'(exp));
    ones = 1'b1;
    for (int k = i + 16; k < txq.size(); k++) if (txq[k] !== 1'b1) ones = 1'b0;
    chk_flag(ones, 1'b1);
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    ser_rxd = 1'b1;
    cmd_enter_hunt = 1'b0;
    cmd_restart_tx = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, APB_EVENT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, APB_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h3000, 32'h0);
    chk_flag(err, 1'b1);
    apb(1'b1, APB_MASK, 32'hff);
    apb(1'b0, APB_MASK, 32'h0);
    chk(rd, 32'(EV_IMPL));
    apb(1'b1, APB_MASK, 32'h02);
    b0 = 8'($random(seed)) & 8'h7f;
    b1 = 8'($random(seed));
    apb(1'b1, ia(8'h40), {16'h0, b0, b1});
    apb(1'b1, ia(8'h21), 32'h2);
    apb(1'b1, ia(8'h22), 32'h80);
    txq.delete();
    apb(1'b1, ia(8'h20), 32'hb800);
    apb(1'b1, ia(8'h21), 32'h5);
    chk_flag(err, 1'b1);
    poll(ia(8'h20));
    chk(32'(rd[15:0]), 32'h3800);
    repeat (40) @(posedge clk);
    tx_check({b0, b1});
    apb(1'b1, APB_EVENT, 32'h0);
    apb(1'b0, APB_EVENT, 32'h0);
    chk(rd, 32'h02);
    chk_flag(host_irq, 1'b1);
    apb(1'b1, APB_EVENT, 32'h02);
    apb(1'b0, APB_EVENT, 32'h0);
    chk(rd, 32'h0);
    chk_flag(host_irq, 1'b0);
    b0 = 8'($random(seed)) & 8'h7f;
    b1 = 8'($random(seed));
    apb(1'b1, 16'h2000 + 16'h0120, {16'h0, 8'($random(seed)), b0});
    apb(1'b1, 16'h2000 + 16'h0124, {16'h0, b1, 8'($random(seed))});
    apb(1'b1, ia(8'h21), 32'h2);
    apb(1'b1, ia(8'h22), 32'h91);
    chk_flag(err, 1'b0);
    txq.delete();
    apb(1'b1, ia(8'h20), 32'he800);
    poll(ia(8'h20));
    chk(32'(rd[15:0]), 32'h6800);
    repeat (40) @(posedge clk);
    tx_check({b0, b1});
    apb(1'b0, APB_EVENT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, APB_MASK, 32'h08);
    apb(1'b1, ia(2), 32'ha1);
    chk_flag(err, 1'b1);
    apb(1'b1, ia(2), 32'ha0);
    apb(1'b1, ia(0), 32'ha000);
    send_frame(9, -1);
    apb(1'b1, ia(1), 32'h4);
    chk_flag(err, 1'b1);
    poll(ia(0));
    chk(32'(rd[15:0]), 32'h2000);
    rx_check();
    apb(1'b0, APB_EVENT, 32'h0);
    chk(rd, 32'h08);
    chk_flag(host_irq, 1'b1);
    apb(1'b1, APB_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk_flag(host_irq, 1'b0);
    apb(1'b1, APB_EVENT, 32'hff);
    apb(1'b1, ia(0), 32'ha000);
    send_frame(9, 4);
    poll(ia(0));
    chk(32'(rd[15:0]), 32'h2008);
    rx_check();
    apb(1'b1, APB_EVENT, 32'hff);
    send_frame(9, -1);
    wait_rx();
    apb(1'b0, APB_EVENT, 32'h0);
    chk(rd & 32'h04, 32'h04);
    apb(1'b1, APB_EVENT, 32'hff);
    apb(1'b1, ia(0), 32'ha000);
    send_frame(3, -1);
    wait_rx();
    cmd_enter_hunt <= 1'b1;
    @(posedge clk);
    cmd_enter_hunt <= 1'b0;
    poll(ia(0));
    chk(32'(rd[15:0]), 32'h2000);
    rx_check();
    final_report();
  end
endmodule
`default_nettype wire

//--- vce_dev.sv
`timescale 1ns/100ps
`default_nettype none
module vce_dev #(
  parameter int BIT_DIV = vce_pkg::BIT_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  vce_link.dev lnk,
  input wire logic ser_rxd,
  output logic ser_txd,
  output logic ser_tick,
  input wire logic cmd_enter_hunt,
  input wire logic cmd_restart_tx
);
  import vce_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RX_CTRL = 4'h1, S_RX_PTR = 4'h2, S_RX_DATA = 4'h3, S_RX_LEN = 4'h4,
    S_RX_CLOSE = 4'h5, S_TX_CTRL = 4'h6, S_TX_LEN = 4'h7, S_TX_PTR = 4'h8, S_TX_DATA = 4'h9,
    S_TX_CLOSE = 4'ha
  } vce_seq_e;

  typedef struct packed {
    logic we;
    logic ext;
    logic [15:0] a;
    logic [15:0] d;
    logic [1:0] be;
  } vce_rq_s;

  typedef struct packed {
    vce_seq_e seq;
    logic [15:0] div;
    logic tick;
    logic txd;
    logic req;
    vce_rq_s rq;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic irq;
    logic [7:0] ev;
    logic [7:0] mask;
    logic hunt;
    logic [8:0] sr;
    logic [2:0] rbits;
    logic [6:0] asm;
    logic [3:0] nbytes;
    logic pend;
    logic [7:0] pbyte;
    logic open;
    logic [15:0] rptr;
    logic [3:0] rlen;
    logic [15:0] rctrl;
    logic se;
    logic ov;
    logic rclose;
    logic [2:0] ridx;
    logic tact;
    logic tgo;
    logic thalt;
    logic tpoll;
    logic [15:0] tctrl;
    logic [15:0] tptr;
    logic [15:0] tleft;
    logic nvalid;
    logic [7:0] nbyte;
    logic [7:0] tsh;
    logic [2:0] tbits;
    logic tclose;
    logic tun;
    logic [2:0] tidx;
  } vce_dev_s;

  localparam vce_dev_s DEV_RST = '{seq: S_IDLE, txd: 1'b1, hunt: 1'b1, sr: 9'h1ff,
    ev: EVENT_RST, mask: MASK_RST, default: '0};

  vce_dev_s r;
  vce_dev_s n;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic [7:0] rx_b;

  function automatic vce_rq_s mk(input logic we, input logic ext, input logic [15:0] a,
      input logic [15:0] d, input logic [1:0] be);
    mk = '{we: we, ext: ext, a: a, d: d, be: be};
  endfunction

  // Descriptors always sit in internal RAM
  function automatic vce_rq_s bd(input logic we, input logic [15:0] base, input logic [2:0] idx,
      input logic [1:0] off, input logic [15:0] d);
    bd = mk(we, 1'b0, base + {11'h0, idx, off}, d, 2'b11);
  endfunction

  // Even byte address is the high lane of a word
  function automatic vce_rq_s wbyte(input logic [15:0] a, input logic ext, input logic [7:0] b);
    wbyte = mk(1'b1, ext, {1'b0, a[15:1]}, {b, b}, a[0] ? 2'b01 : 2'b10);
  endfunction

  always_comb begin
    n = r;
    ev_set = 8'h00;
    ev_clr = 8'h00;
    rx_b = {r.asm, ser_rxd};
    n.tick = 1'b0;
    n.reg_ack = 1'b0;
    if (r.div == 16'(BIT_DIV - 1)) begin
      n.div = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.div = r.div + 16'h0001;
    end
    // ==========================================
    // Register port
    if (lnk.reg_req && !r.reg_ack) begin
      n.reg_ack = 1'b1;
      n.reg_rdata = (lnk.reg_addr == REG_MASK) ? r.mask : r.ev;
      if (lnk.reg_we && lnk.reg_addr == REG_MASK) begin
        n.mask = lnk.reg_wdata & EV_IMPL;
      end else if (lnk.reg_we) begin
        ev_clr = lnk.reg_wdata;
      end
    end
    // ==========================================
    // Memory sequencer; one access at a time, receive first
    case (r.seq)
      S_IDLE: begin
        if (r.pend && r.open) begin
          n.req = 1'b1;
          n.rq = wbyte(r.rptr + {12'h0, r.rlen}, r.rctrl[BD_EXT], r.pbyte);
          n.seq = S_RX_DATA;
        end else if (r.pend) begin
          n.req = 1'b1;
          n.rq = bd(1'b0, RX_TBL, r.ridx, BD_CTRL, 16'h0000);
          n.seq = S_RX_CTRL;
        end else if (r.rclose && r.open) begin
          n.req = 1'b1;
          n.rq = bd(1'b1, RX_TBL, r.ridx, BD_LEN, {12'h0, r.rlen});
          n.seq = S_RX_LEN;
        end else if (r.rclose) begin
          n.rclose = 1'b0;
        end else if (r.tclose) begin
          n.req = 1'b1;
          n.rq = bd(1'b1, TX_TBL, r.tidx, BD_CTRL,
            (r.tctrl & ~(16'h0001 << BD_OWN)) | ({15'h0, r.tun} << BD_UN));
          n.seq = S_TX_CLOSE;
        end else if (r.tact && !r.nvalid && r.tleft != 16'h0000) begin
          n.req = 1'b1;
          n.rq = mk(1'b0, r.tctrl[BD_EXT], {1'b0, r.tptr[15:1]}, 16'h0000, 2'b11);
          n.seq = S_TX_DATA;
        end else if (!r.tact && r.tpoll && !r.thalt) begin
          n.tpoll = 1'b0;
          n.req = 1'b1;
          n.rq = bd(1'b0, TX_TBL, r.tidx, BD_CTRL, 16'h0000);
          n.seq = S_TX_CTRL;
        end
      end
      default: begin
        if (r.req && lnk.mem_ack) begin
          n.req = 1'b0;
          n.seq = S_IDLE;
          case (r.seq)
            S_RX_CTRL: begin
              if (lnk.mem_rdata[BD_OWN]) begin
                n.rctrl = lnk.mem_rdata;
                n.req = 1'b1;
                n.rq = bd(1'b0, RX_TBL, r.ridx, BD_PTR, 16'h0000);
                n.seq = S_RX_PTR;
              end else begin
                ev_set[EV_BSY] = 1'b1;
                n.pend = 1'b0;
                n.hunt = 1'b1;
                n.sr = 9'h1ff;
                n.rclose = 1'b0;
                n.se = 1'b0;
                n.ov = 1'b0;
              end
            end
            S_RX_PTR: begin
              n.rptr = lnk.mem_rdata;
              n.open = 1'b1;
              n.rlen = 4'h0;
              n.req = 1'b1;
              n.rq = wbyte(lnk.mem_rdata, r.rctrl[BD_EXT], r.pbyte);
              n.seq = S_RX_DATA;
            end
            S_RX_DATA: begin
              n.pend = 1'b0;
              n.rlen = r.rlen + 4'h1;
            end
            S_RX_LEN: begin
              n.req = 1'b1;
              n.rq = bd(1'b1, RX_TBL, r.ridx, BD_CTRL,
                (r.rctrl & ~((16'h0001 << BD_OWN) | (16'h0001 << BD_SE) | (16'h0001 << BD_OV)))
                | ({15'h0, r.se} << BD_SE) | ({15'h0, r.ov} << BD_OV));
              n.seq = S_RX_CLOSE;
            end
            S_RX_CLOSE: begin
              ev_set[EV_RXF] = 1'b1;
              n.ridx = r.rctrl[BD_WRAP] ? 3'h0 : r.ridx + 3'h1;
              n.open = 1'b0;
              n.rclose = 1'b0;
              n.se = 1'b0;
              n.ov = 1'b0;
            end
            S_TX_CTRL: begin
              if (lnk.mem_rdata[BD_OWN]) begin
                n.tctrl = lnk.mem_rdata;
                n.req = 1'b1;
                n.rq = bd(1'b0, TX_TBL, r.tidx, BD_LEN, 16'h0000);
                n.seq = S_TX_LEN;
              end
            end
            S_TX_LEN: begin
              n.tleft = lnk.mem_rdata;
              n.req = 1'b1;
              n.rq = bd(1'b0, TX_TBL, r.tidx, BD_PTR, 16'h0000);
              n.seq = S_TX_PTR;
            end
            S_TX_PTR: begin
              n.tptr = lnk.mem_rdata;
              n.tact = 1'b1;
              n.tgo = 1'b0;
              n.tun = 1'b0;
            end
            S_TX_DATA: begin
              n.nbyte = r.tptr[0] ? lnk.mem_rdata[7:0] : lnk.mem_rdata[15:8];
              n.nvalid = 1'b1;
              n.tptr = r.tptr + 16'h0001;
              n.tleft = r.tleft - 16'h0001;
            end
            S_TX_CLOSE: begin
              ev_set[EV_TXE] = r.tun;
              ev_set[EV_TXB] = !r.tun && r.tctrl[BD_INT];
              n.thalt = r.tun;
              n.tidx = r.tctrl[BD_WRAP] ? 3'h0 : r.tidx + 3'h1;
              n.tact = 1'b0;
              n.tgo = 1'b0;
              n.tclose = 1'b0;
              n.nvalid = 1'b0;
            end
            default: n.seq = S_IDLE;
          endcase
        end
      end
    endcase
    // ==========================================
    // Transmit bit engine
    if (cmd_restart_tx) begin
      n.thalt = 1'b0;
    end
    if (r.tick) begin
      if (!r.tact && !r.thalt) begin
        n.tpoll = 1'b1;
      end
      if (r.tbits != 3'h0) begin
        n.txd = r.tsh[7];
        n.tsh = {r.tsh[6:0], 1'b0};
        n.tbits = r.tbits - 3'h1;
      end else if (r.nvalid) begin
        n.txd = r.nbyte[7];
        n.tsh = {r.nbyte[6:0], 1'b0};
        n.tbits = 3'h7;
        n.nvalid = 1'b0;
        n.tgo = 1'b1;
      end else begin
        n.txd = 1'b1;
        // A fetch still owed once sending began is a starved line
        if (r.tact && r.tgo && !r.tclose) begin
          n.tclose = 1'b1;
          n.tun = (r.tleft != 16'h0000);
        end
      end
    end
    // ==========================================
    // Receive bit engine
    if (r.tick) begin
      if (r.hunt) begin
        n.sr = {r.sr[7:0], ser_rxd};
        if ({r.sr[7:0], ser_rxd} == SYNC_PAT) begin
          n.hunt = 1'b0;
          n.asm = 7'h01;
          n.rbits = 3'h1;
          n.nbytes = 4'h0;
        end
      end else if (r.rbits == 3'h7) begin
        n.rbits = 3'h0;
        n.asm = 7'h00;
        n.se = r.se | !rx_b[7];
        n.pend = 1'b1;
        n.pbyte = rx_b;
        n.nbytes = r.nbytes + 4'h1;
        if (r.pend || r.nbytes == FRAME_BYTES - 4'h1) begin
          n.ov = r.ov | r.pend;
          n.hunt = 1'b1;
          n.sr = 9'h1ff;
          n.rclose = 1'b1;
        end
      end else begin
        n.asm = {r.asm[5:0], ser_rxd};
        n.rbits = r.rbits + 3'h1;
      end
    end
    if (cmd_enter_hunt) begin
      n.hunt = 1'b1;
      n.sr = 9'h1ff;
      n.rclose = 1'b1;
    end
    // Set wins over a clear in the same cycle
    n.ev = ((r.ev & ~ev_clr) | ev_set) & EV_IMPL;
    n.irq = |(r.ev & r.mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  assign ser_txd = r.txd;
  assign ser_tick = r.tick;
  assign lnk.mem_req = r.req;
  assign lnk.mem_we = r.rq.we;
  assign lnk.mem_ext = r.rq.ext;
  assign lnk.mem_addr = r.rq.a;
  assign lnk.mem_wdata = r.rq.d;
  assign lnk.mem_be = r.rq.be;
  assign lnk.reg_ack = r.reg_ack;
  assign lnk.reg_rdata = r.reg_rdata;
  assign lnk.irq = r.irq;
endmodule
`default_nettype wire

//--- vce_host.sv
`timescale 1ns/100ps
`default_nettype none
module vce_host #(
  parameter int MEM_WORDS = vce_pkg::MEM_WORDS
) (
  input wire logic clk,
  input wire logic nrst,
  vce_link.host lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic host_irq
);
  import vce_pkg::*;
  localparam int MIW = $clog2(MEM_WORDS);

  typedef enum logic [0:0] {A_IDLE = 1'b0, A_REG = 1'b1} vce_apb_e;

  typedef struct packed {
    vce_apb_e aph;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic mem_ack;
    logic [15:0] mem_rdata;
    logic reg_req;
    logic reg_we;
    logic reg_addr;
    logic [7:0] reg_wdata;
    logic [MEM_WORDS-1:0][15:0] imem;
    logic [MEM_WORDS-1:0][15:0] xmem;
  } vce_host_s;

  vce_host_s r;
  vce_host_s n;
  logic access;
  logic mem_hit;
  logic apb_mem;
  logic refuse;
  logic [MIW-1:0] widx;
  logic [MIW-1:0] dbase;
  logic [MIW-1:0] didx;
  logic [15:0] wd;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.mem_ack = 1'b0;
    n.irq = lnk.irq;
    access = psel && penable && !r.pready;
    widx = paddr[MIW+1:2];
    dbase = {widx[MIW-1:2], 2'b00};
    mem_hit = (paddr[15:12] == APB_INT_WIN || paddr[15:12] == APB_EXT_WIN) && paddr[1:0] == 2'b00
      && ({22'h0, paddr[11:2]} < 32'(MEM_WORDS));
    apb_mem = 1'b0;
    wd = pwdata[15:0];
    refuse = 1'b0;
    didx = lnk.mem_addr[MIW-1:0];
    // ==========================================
    // Descriptor guards on software writes to the tables
    if (paddr[15:12] == APB_INT_WIN && paddr[11:2] < DESC_END) begin
      refuse = r.imem[dbase][BD_OWN];
      if (paddr[11:2] >= TX_START && paddr[3:2] == BD_CTRL) begin
        wd[BD_RSV10] = 1'b0;
        refuse = refuse | (pwdata[BD_OWN] && r.imem[dbase + MIW'(1)] == 16'h0000);
      end
      if (paddr[11:2] < TX_START && paddr[3:2] == BD_PTR) begin
        refuse = refuse | pwdata[0];
      end
    end
    // ==========================================
    // APB slave
    case (r.aph)
      A_IDLE: begin
        if (access && (paddr == APB_EVENT || paddr == APB_MASK)) begin
          n.reg_req = 1'b1;
          n.reg_we = pwrite;
          n.reg_addr = (paddr == APB_MASK) ? REG_MASK : REG_EVENT;
          n.reg_wdata = pwdata[7:0];
          n.aph = A_REG;
        end else if (access && mem_hit) begin
          apb_mem = 1'b1;
          n.pready = 1'b1;
          n.pslverr = pwrite && refuse;
          if (!pwrite) begin
            n.prdata = {16'h0000, (paddr[15:12] == APB_INT_WIN) ? r.imem[widx] : r.xmem[widx]};
          end else if (!refuse && paddr[15:12] == APB_INT_WIN) begin
            n.imem[widx] = wd;
          end else if (!refuse) begin
            n.xmem[widx] = wd;
          end
        end else if (access) begin
          n.pready = 1'b1;
          n.pslverr = 1'b1;
          n.prdata = 32'h00000000;
        end
      end
      A_REG: begin
        if (r.reg_req && lnk.reg_ack) begin
          n.reg_req = 1'b0;
          n.pready = 1'b1;
          n.pslverr = 1'b0;
          n.prdata = {24'h000000, lnk.reg_rdata};
          n.aph = A_IDLE;
        end
      end
      default: n.aph = A_IDLE;
    endcase
    // ==========================================
    // Controller memory port, yields to software for one cycle
    if (lnk.mem_req && !r.mem_ack && !apb_mem) begin
      n.mem_ack = 1'b1;
      if (lnk.mem_ext && lnk.mem_we) begin
        n.xmem[didx] = merge(r.xmem[didx], lnk.mem_wdata, lnk.mem_be);
      end else if (lnk.mem_we) begin
        n.imem[didx] = merge(r.imem[didx], lnk.mem_wdata, lnk.mem_be);
      end else begin
        n.mem_rdata = lnk.mem_ext ? r.xmem[didx] : r.imem[didx];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{aph: A_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign host_irq = r.irq;
  assign lnk.mem_ack = r.mem_ack;
  assign lnk.mem_rdata = r.mem_rdata;
  assign lnk.reg_req = r.reg_req;
  assign lnk.reg_we = r.reg_we;
  assign lnk.reg_addr = r.reg_addr;
  assign lnk.reg_wdata = r.reg_wdata;
endmodule
`default_nettype wire

//--- vce_link.sv
`timescale 1ns/100ps
`default_nettype none
interface vce_link;
  logic mem_req;
  logic mem_we;
  logic mem_ext;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [1:0] mem_be;
  logic mem_ack;
  logic [15:0] mem_rdata;
  logic reg_req;
  logic reg_we;
  logic reg_addr;
  logic [7:0] reg_wdata;
  logic reg_ack;
  logic [7:0] reg_rdata;
  logic irq;
  modport dev (output mem_req, mem_we, mem_ext, mem_addr, mem_wdata, mem_be, input mem_ack, mem_rdata,
    input reg_req, reg_we, reg_addr, reg_wdata, output reg_ack, reg_rdata, irq);
  modport host (input mem_req, mem_we, mem_ext, mem_addr, mem_wdata, mem_be, output mem_ack, mem_rdata,
    output reg_req, reg_we, reg_addr, reg_wdata, input reg_ack, reg_rdata, irq);
endinterface
`default_nettype wire

//--- vce_link_sva.sv
`timescale 1ns/100ps
`default_nettype none
module vce_link_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_ext,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic irq
);
  // ==========================================
  // Shadow of the enable register, taken from completed writes
  logic [7:0] mask_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= 8'h00;
    end else if (reg_req && reg_ack && reg_we && reg_addr) begin
      // Unused event positions are not stored
      mask_q <= reg_wdata & vce_pkg::EV_IMPL;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Properties
  property p_reg_answer;
    reg_req && !reg_ack |=> reg_ack;
  endproperty
  a_reg_answer: assert property (p_reg_answer) else $error("register request not answered");
  property p_reg_pulse;
    reg_ack |=> !reg_ack;
  endproperty
  a_reg_pulse: assert property (p_reg_pulse) else $error("register answer longer than one cycle");
  property p_event_bits;
    reg_ack && !reg_we && !reg_addr |-> (reg_rdata & 8'he1) == 8'h00;
  endproperty
  a_event_bits: assert property (p_event_bits) else $error("unused event bit reads one");
  property p_mask_read;
    reg_ack && !reg_we && reg_addr |-> reg_rdata == mask_q;
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("enable register read differs");
  // Irq is registered after the enable register, so allow it to settle
  property p_irq_masked;
    (mask_q == 8'h00) [*3] |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all events disabled");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_ext);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request changed before answer");
  property p_mem_answer;
    $rose(mem_req) |-> ##[1:12] mem_ack;
  endproperty
  a_mem_answer: assert property (p_mem_answer) else $error("memory request not answered");
  // A chained access may follow at once, but never the same one again
  property p_mem_drop;
    mem_ack |=> !mem_req || !$stable(mem_addr) || !$stable(mem_we);
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("memory request kept after answer");
  c_irq: cover property ($rose(irq));
  c_mem_write: cover property (mem_ack && mem_we);
  c_mask_write: cover property (reg_ack && reg_we && reg_addr);
endmodule
`default_nettype wire

//--- vce_pkg.sv
package vce_pkg;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BIT_RATE_HZ = 64_000;
  localparam int BIT_DIV = CLK_HZ / BIT_RATE_HZ;
  // ==========================================
  // Descriptor tables, word addresses in internal RAM
  localparam logic [15:0] RX_TBL = 16'h0000;
  localparam logic [15:0] TX_TBL = 16'h0020;
  localparam logic [9:0] DESC_END = 10'h040;
  localparam logic [9:0] TX_START = 10'h020;
  localparam logic [1:0] BD_CTRL = 2'h0;
  localparam logic [1:0] BD_LEN = 2'h1;
  localparam logic [1:0] BD_PTR = 2'h2;
  localparam int BD_OWN = 15;
  localparam int BD_EXT = 14;
  localparam int BD_WRAP = 13;
  localparam int BD_INT = 12;
  localparam int BD_LAST = 11;
  localparam int BD_RSV10 = 10;
  localparam int BD_SE = 3;
  localparam int BD_OV = 1;
  localparam int BD_UN = 1;
  // ==========================================
  // Frame
  localparam logic [3:0] FRAME_BYTES = 4'h9;
  localparam logic [8:0] SYNC_PAT = 9'h001;
  // ==========================================
  // Event and mask registers
  localparam int EV_TXB = 1;
  localparam int EV_BSY = 2;
  localparam int EV_RXF = 3;
  localparam int EV_TXE = 4;
  localparam logic [7:0] EV_IMPL = 8'h1e;
  localparam logic [7:0] EVENT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic REG_EVENT = 1'b0;
  localparam logic REG_MASK = 1'b1;
  // ==========================================
  // Host APB map
  localparam logic [15:0] APB_EVENT = 16'h0000;
  localparam logic [15:0] APB_MASK = 16'h0004;
  localparam logic [3:0] APB_INT_WIN = 4'h1;
  localparam logic [3:0] APB_EXT_WIN = 4'h2;
  localparam int MEM_WORDS = 128;
endpackage
